// ===== hdl/rcw_pkg.sv
// rcw_pkg: shared constants, types and decode functions for the reset-cause block
package rcw_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int REG_AW = 4;
   localparam int REG_DW = 16;
   localparam int PC_W   = 24;
   localparam int LVL_W  = 4;

   // ----------------------------------------------------------------
   // register offsets (byte addresses on the plain register port)
   // ----------------------------------------------------------------
   localparam logic [REG_AW-1:0] OFS_RCSR   = 4'h0;
   localparam logic [REG_AW-1:0] OFS_LVSTAT = 4'h4;

   // ----------------------------------------------------------------
   // reset_control_status_reg field positions
   // ----------------------------------------------------------------
   localparam int BIT_POWER_ON   = 0;
   localparam int BIT_BROWN_OUT  = 1;
   localparam int BIT_IDLE       = 2;
   localparam int BIT_SLEEP      = 3;
   localparam int BIT_WDT_TO     = 4;
   localparam int BIT_WDT_SOFTEN = 5;
   localparam int BIT_SW_RESET   = 6;
   localparam int BIT_EXT_RESET  = 7;
   localparam int LVL_SEL_LSB    = 8;
   localparam int LVL_SEL_MSB    = 11;
   localparam int BIT_LVD_EN     = 12;
   localparam int BIT_REF_STABLE = 13;
   localparam int BIT_ILLEGAL_OP = 14;
   localparam int BIT_TRAP_RST   = 15;
   localparam int BIT_LV_EVENT   = 0;

   localparam logic [REG_DW-1:0] M_POR  = 16'h0001;
   localparam logic [REG_DW-1:0] M_BOR  = 16'h0002;
   localparam logic [REG_DW-1:0] M_IDLE = 16'h0004;
   localparam logic [REG_DW-1:0] M_SLP  = 16'h0008;
   localparam logic [REG_DW-1:0] M_WDOG = 16'h0010;
   localparam logic [REG_DW-1:0] M_SOFT = 16'h0040;
   localparam logic [REG_DW-1:0] M_EXT  = 16'h0080;
   localparam logic [REG_DW-1:0] M_IOP  = 16'h4000;
   localparam logic [REG_DW-1:0] M_TRAP = 16'h8000;

   // power-on value: power-on and brown-out set, everything else clear
   localparam logic [REG_DW-1:0] RCSR_POR_VALUE = 16'h0003;
   // reference-stable bit is read-only
   localparam logic [REG_DW-1:0] RCSR_WR_MASK   = 16'hDFFF;

   // ----------------------------------------------------------------
   // program counter load values
   // ----------------------------------------------------------------
   localparam logic [PC_W-1:0] RESET_VECTOR   = 24'h000000;
   localparam logic [PC_W-1:0] CLKFAIL_VECTOR = 24'h000004;
   localparam logic [PC_W-1:0] PC_STEP        = 24'h000002;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 8;
   localparam int REF_SETTLE_NS   = 20000;
   localparam int REF_SETTLE_CYC  = (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WDT_PRESCALE    = 16;
   localparam int WDT_BITS        = 8;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      EV_NONE      = 4'h0,
      EV_BOR       = 4'h1,
      EV_EXT_RUN   = 4'h2,
      EV_EXT_SLEEP = 4'h3,
      EV_EXT_IDLE  = 4'h4,
      EV_WDT_RST   = 4'h5,
      EV_WDT_WAKE  = 4'h6,
      EV_SOFT      = 4'h7,
      EV_TRAP      = 4'h8,
      EV_IOP       = 4'h9,
      EV_CLKFAIL   = 4'hA,
      EV_INT_WAKE  = 4'hB
   } rcw_event_t;

   typedef struct packed {
      logic brown_out;
      logic ext_pin;
      logic soft_reset;
      logic trap_lockup;
      logic illegal_op;
      logic clock_fail;
      logic int_wake;
   } rcw_cause_t;

   typedef struct packed {
      logic [REG_DW-1:0] set;
      logic [REG_DW-1:0] clr;
   } rcw_mask_t;

   // ----------------------------------------------------------------
   // flag set/clear masks per event; bits in neither stay unchanged
   // ----------------------------------------------------------------
   function automatic rcw_mask_t rcw_event_mask(input rcw_event_t ev);
      rcw_mask_t m;
      m.set = '0;
      m.clr = '0;
      case (ev)
         EV_BOR: begin
            m.set = M_BOR;
            m.clr = M_POR;
         end
         EV_EXT_RUN: begin
            m.set = M_EXT;
            m.clr = M_SOFT | M_WDOG | M_IDLE | M_SLP;
         end
         EV_EXT_SLEEP: begin
            m.set = M_EXT | M_SLP;
            m.clr = M_WDOG | M_IDLE;
         end
         EV_EXT_IDLE: begin
            m.set = M_EXT | M_IDLE;
            m.clr = M_WDOG | M_SLP;
         end
         EV_WDT_RST: begin
            m.set = M_WDOG;
            m.clr = M_EXT | M_SOFT | M_IDLE | M_SLP;
         end
         EV_WDT_WAKE: m.set = M_WDOG | M_SLP;
         EV_SOFT: begin
            m.set = M_SOFT;
            m.clr = M_EXT | M_WDOG | M_IDLE | M_SLP;
         end
         EV_TRAP:     m.set = M_TRAP;
         EV_IOP:      m.set = M_IOP;
         EV_INT_WAKE: m.set = M_SLP;
         default:     m.set = '0;
      endcase
      return m;
   endfunction : rcw_event_mask

   // true for events that restart the device rather than resume it
   function automatic logic rcw_is_reset(input rcw_event_t ev);
      return (ev != EV_NONE) && (ev != EV_WDT_WAKE) && (ev != EV_INT_WAKE) &&
             (ev != EV_CLKFAIL);
   endfunction : rcw_is_reset

endpackage : rcw_pkg

// ===== hdl/rcw_wdt.sv
// rcw_wdt: free-running watchdog counter with prescaler and overflow pulse
`timescale 1ns/10ps
module rcw_wdt
   import rcw_pkg::*;
#(
   parameter int PRESCALE = WDT_PRESCALE,
   parameter int BITS     = WDT_BITS
) (
   // clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   // control
   input  wire logic enable_i,
   input  wire logic restart_i,
   // status
   output logic      overflow_o
);

   localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;

   logic [PW-1:0]   pre;
   logic [BITS-1:0] cnt;
   wire             tick = (pre == PW'(PRESCALE - 1));

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   // the tick stands in for the on-chip rc oscillator; with one clock the
   // count would stop if the system clock stopped
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre        <= '0;
         cnt        <= '0;
         overflow_o <= 1'b0;
      end else begin
         overflow_o <= 1'b0;
         if (restart_i || !enable_i) begin
            pre <= '0;
            cnt <= '0;
         end else begin
            pre <= tick ? '0 : pre + PW'(1);
            if (tick) begin
               cnt <= cnt + BITS'(1);
               overflow_o <= &cnt;
            end
         end
      end
   end

endmodule : rcw_wdt

// ===== hdl/rcw_lvd.sv
// rcw_lvd: low-voltage detect compare with reference settle timer
`timescale 1ns/10ps
module rcw_lvd
   import rcw_pkg::*;
#(
   parameter int SETTLE_CYC = REF_SETTLE_CYC
) (
   // clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             rst_n_i,
   // control
   input  wire logic             enable_i,
   input  wire logic [LVL_W-1:0] threshold_i,
   input  wire logic [LVL_W-1:0] supply_level_i,
   // status
   output logic                  stable_o,
   output logic                  below_o
);

   localparam int CW = $clog2(SETTLE_CYC + 1);

   logic [CW-1:0] cnt;
   wire           settled = (cnt == CW'(SETTLE_CYC));

   // ----------------------------------------------------------------
   // settle timer and compare
   // ----------------------------------------------------------------
   // compare is blocked until the reference settles to avoid false trips
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt      <= '0;
         stable_o <= 1'b0;
         below_o  <= 1'b0;
      end else begin
         if (!enable_i) begin
            cnt <= '0;
         end else if (!settled) begin
            cnt <= cnt + CW'(1);
         end
         stable_o <= enable_i && settled;
         below_o  <= enable_i && stable_o && (supply_level_i < threshold_i);
      end
   end

endmodule : rcw_lvd

// ===== hdl/rcw_top.sv
// rcw_top: reset-cause flags, pc load, watchdog and low-voltage detect
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/10ps
// Overview of operation
// - resets load pc 0x000000, clock-fail trap 0x000004, watchdog wake pc+2
// - all cause flags read/write; each event sets and clears only the flags listed below
// - power-on sets power-on and brown-out flags, clears all others
// - brown-out sets brown-out, clears power-on, others unchanged
// - pin reset when running sets external, clears software/watchdog/idle/sleep
// - software reset sets software, clears external/watchdog/idle/sleep
// - pin reset in sleep sets external and sleep, clears watchdog and idle
// - pin reset in idle sets external and idle, clears watchdog and sleep
// - interrupt wake from sleep sets sleep, jumps to interrupt vector
// - watchdog is a free-running counter on its own oscillator tick
// - watchdog forced on when configuration enable is 1
// - otherwise software enable bit 5 runs or stops the watchdog
// - overflow outside sleep resets, sets watchdog, clears ext/sw/idle/sleep
// - overflow in sleep wakes, sets watchdog and sleep flags
// - threshold select at bits 11:8, detector enable at bit 12
// - read-only bit 13 shows reference has stabilised
// - trap lockup sets trap flag; illegal operation sets illegal flag
module rcw_top
   import rcw_pkg::*;
#(
   parameter int WDT_PRE_DIV  = WDT_PRESCALE,
   parameter int WDT_CNT_BITS = WDT_BITS,
   parameter int REF_CYC      = REF_SETTLE_CYC
) (
   // clock and reset
   input  wire logic               ref_clk_i,
   input  wire logic               rst_n_i,
   // register port
   input  wire logic [REG_AW-1:0]  reg_addr_i,
   input  wire logic [REG_DW-1:0]  reg_wdata_i,
   input  wire logic               reg_wr_i,
   input  wire logic               reg_rd_i,
   output logic      [REG_DW-1:0]  reg_rdata_o,
   // core events and state
   input  wire rcw_cause_t         cause_i,
   input  wire logic               sleep_mode_i,
   input  wire logic               idle_mode_i,
   input  wire logic               watchdog_config_enable_i,
   input  wire logic               watchdog_clear_instruction_i,
   input  wire logic [PC_W-1:0]    pc_i,
   input  wire logic [PC_W-1:0]    int_vector_i,
   // analog front end
   input  wire logic [LVL_W-1:0]   supply_level_i,
   // outputs to core
   output logic                    pc_load_o,
   output logic      [PC_W-1:0]    pc_value_o,
   output logic                    device_reset_o,
   output logic                    wake_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [REG_DW-1:0] rcsr;
   logic              lv_event;
   logic              wdt_ovf;
   logic              ref_stable;
   logic              lvd_below;

   // ----------------------------------------------------------------
   // event selection
   // ----------------------------------------------------------------
   // one event per cycle; a lower-priority event in the same cycle is
   // dropped, even when the winner is a watchdog wake or clock failure that resumes the core
   wire rcw_event_t ext_ev = sleep_mode_i ? EV_EXT_SLEEP :
                             idle_mode_i  ? EV_EXT_IDLE  : EV_EXT_RUN;
   wire rcw_event_t wdt_ev = sleep_mode_i ? EV_WDT_WAKE : EV_WDT_RST;
   wire rcw_event_t ev =
      cause_i.brown_out               ? EV_BOR     :
      cause_i.ext_pin                 ? ext_ev     :
      wdt_ovf                         ? wdt_ev     :
      cause_i.soft_reset              ? EV_SOFT    :
      cause_i.trap_lockup             ? EV_TRAP    :
      cause_i.illegal_op              ? EV_IOP     :
      cause_i.clock_fail              ? EV_CLKFAIL :
      (cause_i.int_wake && sleep_mode_i) ? EV_INT_WAKE : EV_NONE;

   wire rcw_mask_t ev_mask   = rcw_event_mask(ev);
   wire            ev_reset  = rcw_is_reset(ev);
   wire            ev_wake   = (ev == EV_WDT_WAKE) || (ev == EV_INT_WAKE);

   // pc load value per event
   wire [PC_W-1:0] next_pc_value =
      (ev == EV_CLKFAIL)  ? CLKFAIL_VECTOR   :
      (ev == EV_WDT_WAKE) ? pc_i + PC_STEP   :
      (ev == EV_INT_WAKE) ? int_vector_i     :
                            RESET_VECTOR;

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   wire sel_rcsr   = (reg_addr_i == OFS_RCSR);
   wire sel_lvstat = (reg_addr_i == OFS_LVSTAT);
   wire wr_rcsr    = reg_wr_i && sel_rcsr;
   wire wr_lvstat  = reg_wr_i && sel_lvstat;

   // software write first, then the event on top: a hardware event in the
   // same cycle as a write wins for the flags it names
   wire [REG_DW-1:0] rcsr_sw = wr_rcsr ?
                               ((reg_wdata_i & RCSR_WR_MASK) | (rcsr & ~RCSR_WR_MASK)) :
                               rcsr;
   wire [REG_DW-1:0] next_rcsr = (rcsr_sw & ~ev_mask.clr) | ev_mask.set;

   // low-voltage flag: write one to clear, a new trip wins over the clear
   wire next_lv_event = lvd_below ||
                        (lv_event && !(wr_lvstat && reg_wdata_i[BIT_LV_EVENT]));

   wire [REG_DW-1:0] rcsr_view = rcsr | (REG_DW'(ref_stable) << BIT_REF_STABLE);
   wire [REG_DW-1:0] lvstat_view = REG_DW'(lv_event) << BIT_LV_EVENT;
   wire [REG_DW-1:0] next_rdata = !reg_rd_i  ? '0          :
                                  sel_rcsr   ? rcsr_view   :
                                  sel_lvstat ? lvstat_view : '0;

   // ----------------------------------------------------------------
   // watchdog and detector controls
   // ----------------------------------------------------------------
   wire wdt_enable  = watchdog_config_enable_i || rcsr[BIT_WDT_SOFTEN];
   wire wdt_restart = watchdog_clear_instruction_i || ev_reset || ev_wake;
   wire lvd_enable  = rcsr[BIT_LVD_EN];
   wire [LVL_W-1:0] lvd_threshold = rcsr[LVL_SEL_MSB:LVL_SEL_LSB];

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // the asynchronous reset is the power-on reset
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rcsr     <= RCSR_POR_VALUE;
         lv_event <= 1'b0;
      end else begin
         rcsr     <= next_rcsr;
         lv_event <= next_lv_event;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o    <= '0;
         pc_load_o      <= 1'b0;
         pc_value_o     <= RESET_VECTOR;
         device_reset_o <= 1'b0;
         wake_o         <= 1'b0;
      end else begin
         reg_rdata_o    <= next_rdata;
         pc_load_o      <= (ev != EV_NONE);
         pc_value_o     <= next_pc_value;
         device_reset_o <= ev_reset;
         wake_o         <= ev_wake;
      end
   end

   // ----------------------------------------------------------------
   // submodules
   // ----------------------------------------------------------------
   rcw_wdt #(
      .PRESCALE (WDT_PRE_DIV),
      .BITS     (WDT_CNT_BITS)
   ) u_wdt (
      .ref_clk_i  (ref_clk_i),
      .rst_n_i    (rst_n_i),
      .enable_i   (wdt_enable),
      .restart_i  (wdt_restart),
      .overflow_o (wdt_ovf)
   );

   rcw_lvd #(
      .SETTLE_CYC (REF_CYC)
   ) u_lvd (
      .ref_clk_i      (ref_clk_i),
      .rst_n_i        (rst_n_i),
      .enable_i       (lvd_enable),
      .threshold_i    (lvd_threshold),
      .supply_level_i (supply_level_i),
      .stable_o       (ref_stable),
      .below_o        (lvd_below)
   );

endmodule : rcw_top

// ===== testbench/rcw_top_properties.sv
// rcw_top_properties: port-level checks for the reset-cause block
`timescale 1ns/10ps
module rcw_top_properties
   import rcw_pkg::*;
#(
   parameter int WDT_PRE_DIV  = WDT_PRESCALE,
   parameter int WDT_CNT_BITS = WDT_BITS,
   parameter int REF_CYC      = REF_SETTLE_CYC
) (
   // clock and reset
   input wire logic              ref_clk_i,
   input wire logic              rst_n_i,
   // register port
   input wire logic [REG_AW-1:0] reg_addr_i,
   input wire logic [REG_DW-1:0] reg_wdata_i,
   input wire logic              reg_wr_i,
   input wire logic              reg_rd_i,
   input wire logic [REG_DW-1:0] reg_rdata_o,
   // core side
   input wire rcw_cause_t        cause_i,
   input wire logic              sleep_mode_i,
   input wire logic              idle_mode_i,
   input wire logic              watchdog_config_enable_i,
   input wire logic              watchdog_clear_instruction_i,
   input wire logic [PC_W-1:0]   pc_i,
   input wire logic [PC_W-1:0]   int_vector_i,
   input wire logic [LVL_W-1:0]  supply_level_i,
   input wire logic              pc_load_o,
   input wire logic [PC_W-1:0]   pc_value_o,
   input wire logic              device_reset_o,
   input wire logic              wake_o
);
   // prescaler phase is not promised to restart, hence one extra prescale period
   localparam int WDT_LIMIT = (WDT_PRE_DIV << WDT_CNT_BITS) + WDT_PRE_DIV + 4;
   logic [15:0] wdt_age;

   default clocking
      @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wdt_age <= 16'h0000;
      end else if (device_reset_o || wake_o || watchdog_clear_instruction_i ||
                   !watchdog_config_enable_i) begin
         wdt_age <= 16'h0000;
      end else begin
         wdt_age <= wdt_age + 16'h0001;
      end
   end

   sequence s_reset_cause;
      cause_i.brown_out || cause_i.ext_pin || cause_i.soft_reset || cause_i.trap_lockup ||
      cause_i.illegal_op;
   endsequence
   sequence s_reset_load;
      pc_load_o && device_reset_o && !wake_o && pc_value_o == RESET_VECTOR;
   endsequence
   sequence s_int_wake;
      cause_i == 7'h01 && sleep_mode_i;
   endsequence

   AST_RESET_LOAD: assert property (s_reset_cause |=> s_reset_load)
      else $error("reset event did not load the reset vector");
   AST_CLK_FAIL: assert property (cause_i == 7'h02 |=>
      pc_load_o && (device_reset_o || wake_o || pc_value_o == CLKFAIL_VECTOR))
      else $error("clock failure did not load the trap vector");
   AST_INT_WAKE: assert property (s_int_wake |=> wake_o && pc_load_o && !device_reset_o &&
      (pc_value_o == $past(int_vector_i) || pc_value_o == $past(pc_i) + PC_STEP))
      else $error("interrupt wake from sleep misbehaved");
   AST_INT_REFUSED: assert property (cause_i == 7'h01 && !sleep_mode_i |=> !wake_o)
      else $error("interrupt woke a running core");
   AST_ONE_KIND: assert property (!(device_reset_o && wake_o))
      else $error("reset and wake pulsed together");
   AST_LOAD_WITH: assert property ((device_reset_o || wake_o) |-> pc_load_o)
      else $error("reset or wake without pc load");
   AST_RDATA_IDLE: assert property ((!reg_rd_i || (reg_addr_i != OFS_RCSR &&
      reg_addr_i != OFS_LVSTAT)) |=> reg_rdata_o == 16'h0000)
      else $error("read data not zero outside a mapped read");
   AST_WDT_BOUND: assert property (wdt_age <= 16'(WDT_LIMIT))
      else $error("forced watchdog never timed out");
endmodule : rcw_top_properties

bind rcw_top rcw_top_properties #(
   .WDT_PRE_DIV(WDT_PRE_DIV), .WDT_CNT_BITS(WDT_CNT_BITS), .REF_CYC(REF_CYC)
) u_props (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .cause_i(cause_i), .sleep_mode_i(sleep_mode_i),
   .idle_mode_i(idle_mode_i), .watchdog_config_enable_i(watchdog_config_enable_i),
   .watchdog_clear_instruction_i(watchdog_clear_instruction_i), .pc_i(pc_i),
   .int_vector_i(int_vector_i), .supply_level_i(supply_level_i), .pc_load_o(pc_load_o),
   .pc_value_o(pc_value_o), .device_reset_o(device_reset_o), .wake_o(wake_o)
);

// ===== testbench/rcw_top_tb.sv
// rcw_top_tb: self-checking bench for the reset-cause block
`timescale 1ns/10ps
module rcw_top_tb
   import rcw_pkg::*;
;
   // short counts keep watchdog and settle waits to a few dozen cycles
   localparam int PRE = 2;
   localparam int CB  = 3;
   localparam int RC  = 4;
   localparam logic [PC_W-1:0]   VEC = 24'h000150;
   localparam logic [REG_DW-1:0] K4  = M_WDOG | M_IDLE | M_SLP;
   // lrw: expected {pc_load, device_reset, wake}; si: {sleep, idle}
   typedef struct packed {
      rcw_cause_t        c;
      logic [1:0]        si;
      logic [REG_DW-1:0] set;
      logic [REG_DW-1:0] clr;
      logic [PC_W-1:0]   pc;
      logic [2:0]        lrw;
   } rcw_row_t;
   rcw_row_t rows [12] = '{
      '{7'h40, 2'h0, M_BOR, M_POR, RESET_VECTOR, 3'h6},
      '{7'h20, 2'h0, M_EXT, M_SOFT | K4, RESET_VECTOR, 3'h6},
      '{7'h20, 2'h2, M_EXT | M_SLP, M_WDOG | M_IDLE, RESET_VECTOR, 3'h6},
      '{7'h20, 2'h1, M_EXT | M_IDLE, M_WDOG | M_SLP, RESET_VECTOR, 3'h6},
      '{7'h10, 2'h0, M_SOFT, M_EXT | K4, RESET_VECTOR, 3'h6},
      '{7'h08, 2'h0, M_TRAP, 16'h0000, RESET_VECTOR, 3'h6},
      '{7'h04, 2'h0, M_IOP, 16'h0000, RESET_VECTOR, 3'h6},
      '{7'h02, 2'h0, 16'h0000, 16'h0000, CLKFAIL_VECTOR, 3'h4},
      '{7'h01, 2'h2, M_SLP, 16'h0000, VEC, 3'h5},
      '{7'h01, 2'h0, 16'h0000, 16'h0000, RESET_VECTOR, 3'h0},
      '{7'h60, 2'h0, M_BOR, M_POR, RESET_VECTOR, 3'h6},
      '{7'h14, 2'h0, M_SOFT, M_EXT | K4, RESET_VECTOR, 3'h6}};
   logic              ref_clk_i;
   logic              rst_n_i;
   logic [REG_AW-1:0] reg_addr_i;
   logic [REG_DW-1:0] reg_wdata_i;
   logic              reg_wr_i;
   logic              reg_rd_i;
   logic [REG_DW-1:0] reg_rdata_o;
   rcw_cause_t        cause_i;
   logic              sleep_mode_i;
   logic              idle_mode_i;
   logic              cfg_en;
   logic              wdt_clr;
   logic [PC_W-1:0]   pc_i;
   logic [LVL_W-1:0]  supply_level_i;
   logic              pc_load_o;
   logic [PC_W-1:0]   pc_value_o;
   logic              device_reset_o;
   logic              wake_o;
   int                n_errors    = 0;
   int                check_count = 0;
   int                n_evt       = 0;

   rcw_top #(.WDT_PRE_DIV(PRE), .WDT_CNT_BITS(CB), .REF_CYC(RC)) uut (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .cause_i(cause_i), .sleep_mode_i(sleep_mode_i),
      .idle_mode_i(idle_mode_i), .watchdog_config_enable_i(cfg_en),
      .watchdog_clear_instruction_i(wdt_clr), .pc_i(pc_i), .int_vector_i(VEC),
      .supply_level_i(supply_level_i), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o),
      .device_reset_o(device_reset_o), .wake_o(wake_o));

   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) if (device_reset_o || wake_o) n_evt <= n_evt + 1;

   task automatic close_out();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] v);
      @(posedge ref_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= v;
      reg_wr_i    <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [REG_AW-1:0] a, output logic [REG_DW-1:0] v);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      v = reg_rdata_o;
   endtask : rd
   task automatic wait_evt(input int n);
      int k = 0;
      while (k < n && device_reset_o !== 1'b1 && wake_o !== 1'b1) begin
         @(posedge ref_clk_i);
         #1;
         k++;
      end
      if (k == n) begin
         n_errors++;
         $display("unexpected at %0t: no watchdog event", $time);
         close_out();
      end
   endtask : wait_evt
   task automatic ev(input rcw_row_t r, input logic [REG_DW-1:0] init);
      logic [REG_DW-1:0] v;
      wr(OFS_RCSR, init);
      @(posedge ref_clk_i);
      cause_i      <= r.c;
      sleep_mode_i <= r.si[1];
      idle_mode_i  <= r.si[0];
      @(posedge ref_clk_i);
      cause_i      <= '0;
      sleep_mode_i <= 1'b0;
      idle_mode_i  <= 1'b0;
      #1;
      chk({21'h0, pc_load_o, device_reset_o, wake_o}, {21'h0, r.lrw});
      if (r.lrw[2]) chk(pc_value_o, r.pc);
      rd(OFS_RCSR, v);
      chk({8'h00, v & 16'hDFFF}, {8'h00, (init & ~r.clr) | r.set});
   endtask : ev

   initial begin
      logic [REG_DW-1:0] d;
      int                b;
      rst_n_i = 1'b0;
      reg_addr_i = '0;
      reg_wdata_i = '0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      cause_i = '0;
      sleep_mode_i = 1'b0;
      idle_mode_i = 1'b0;
      cfg_en = 1'b0;
      wdt_clr = 1'b0;
      pc_i = 24'h001230;
      supply_level_i = 4'hF;
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      rd(OFS_RCSR, d);
      chk({8'h00, d & 16'hDFFF}, {8'h00, RCSR_POR_VALUE});
      rd(OFS_LVSTAT, d);
      chk({8'h00, d}, 24'h000000);
      foreach (rows[j]) begin
         ev(rows[j], 16'hC0DF);
         ev(rows[j], 16'h0000);
      end
      // ------------------------------------------------------------
      // watchdog: stopped, soft enable, forced with clears, sleep wake
      // ------------------------------------------------------------
      wr(OFS_RCSR, 16'h0000);
      b = n_evt;
      repeat (40) @(posedge ref_clk_i);
      chk(24'(n_evt - b), 24'h000000);
      wr(OFS_RCSR, 16'h0020);
      wait_evt(40);
      chk({21'h0, pc_load_o, device_reset_o, wake_o}, 24'h000006);
      chk(pc_value_o, RESET_VECTOR);
      rd(OFS_RCSR, d);
      chk({8'h00, d & 16'hC0DF}, {8'h00, M_WDOG});
      wr(OFS_RCSR, 16'h0000);
      cfg_en <= 1'b1;
      b = n_evt;
      repeat (15) begin
         @(posedge ref_clk_i);
         wdt_clr <= 1'b1;
         @(posedge ref_clk_i);
         wdt_clr <= 1'b0;
         repeat (2) @(posedge ref_clk_i);
      end
      chk(24'(n_evt - b), 24'h000000);
      pc_i <= 24'h00ABC0;
      sleep_mode_i <= 1'b1;
      wait_evt(40);
      chk({21'h0, pc_load_o, device_reset_o, wake_o}, 24'h000005);
      chk(pc_value_o, 24'h00ABC2);
      @(posedge ref_clk_i);
      sleep_mode_i <= 1'b0;
      cfg_en <= 1'b0;
      rd(OFS_RCSR, d);
      chk({8'h00, d & 16'hC0DF}, {8'h00, M_WDOG | M_SLP});
      // unmapped place: reads zero, write leaves the flags alone
      wr(4'h8, 16'hFFFF);
      rd(4'h8, d);
      chk({8'h00, d}, 24'h000000);
      rd(OFS_RCSR, d);
      chk({8'h00, d & 16'hC0DF}, {8'h00, M_WDOG | M_SLP});
      // low-voltage detect: settle, event, clear, read-only status
      wr(OFS_RCSR, 16'h1F00);
      repeat (RC + 4) @(posedge ref_clk_i);
      rd(OFS_RCSR, d);
      chk({8'h00, d}, 24'h003F00);
      @(posedge ref_clk_i);
      supply_level_i <= 4'h3;
      repeat (4) @(posedge ref_clk_i);
      rd(OFS_LVSTAT, d);
      chk({8'h00, d}, 24'h000001);
      @(posedge ref_clk_i);
      supply_level_i <= 4'hF;
      wr(OFS_LVSTAT, 16'h0001);
      rd(OFS_LVSTAT, d);
      chk({8'h00, d}, 24'h000000);
      wr(OFS_RCSR, 16'h1000);
      rd(OFS_RCSR, d);
      chk({8'h00, d}, 24'h003000);
      // second power-on reset in mid-run
      wr(OFS_RCSR, 16'hC0DC);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      rd(OFS_RCSR, d);
      chk({8'h00, d & 16'hDFFF}, {8'h00, RCSR_POR_VALUE});
      close_out();
   end
endmodule : rcw_top_tb
